// >>> verilog/bit_timing_defs.svh
// Offsets, field positions, reset values and constants of the bit timing block.
// Included by bare name; definitions only.
`ifndef BIT_TIMING_DEFS_SVH
`define BIT_TIMING_DEFS_SVH
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_BIT_TIMING 12'h00c
`define OFS_PRESCALER_EXT 12'h018
`define RST_CONTROL 32'h00000001
`define RST_BIT_TIMING 16'h2301
`define RST_PRESCALER_EXT 4'h0
`define CTL_INIT 0
`define STS_IDLE 0
`define STS_RX 1
`define STS_STUFF_ERR 2
`define STS_CRC_ZERO 3
`define STS_CRC_LSB 16
`define BRP_LSB 0
`define SJW_LSB 6
`define SEGMENT_ONE_FIELD_LSB 8
`define SEGMENT_TWO_FIELD_LSB 12
`define REF_CLK_HZ 8000000
`define SYS_CLK_HZ 100000000
`define STUFF_RUN 3'h5
`define IDLE_BITS 4'hb
`define CRC_POLY 15'h4599
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> verilog/bit_timing_pkg.sv
// Types shared by the bit timing block.
// Constants live in bit_timing_defs.svh.
package bit_timing_pkg;
   typedef enum logic [1:0] {SEG_SYNC, SEG_ONE, SEG_TWO} seg_t;
   typedef enum logic [2:0] {REG_NONE, REG_CONTROL, REG_STATUS, REG_TIMING,
      REG_EXT} reg_id_t;
endpackage

// >>> verilog/can_bit_timing_logic.sv
// Bit timing logic of a CAN protocol controller with an AXI4-Lite register slave.
// Assumes rx_pin comes from a transceiver (async), frame logic on aclk.
`timescale 1ns/1ps
`include "bit_timing_defs.svh"
module can_bit_timing_logic (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_pin,
   output logic tx_pin,
   input wire logic tx_bit,
   input wire logic stuff_en,
   input wire logic crc_clear,
   output logic tx_taken,
   output logic rx_bit,
   output logic rx_valid,
   output logic sample_point,
   output logic bus_idle,
   output logic stuff_error,
   output logic [14:0] crc
);

   // Address decode shared by the read and write paths
   function automatic bit_timing_pkg::reg_id_t decode(input logic [11:0] a);
      if (a[11:2] == `OFS_CONTROL >> 2) begin
         decode = bit_timing_pkg::REG_CONTROL;
      end else if (a[11:2] == `OFS_STATUS >> 2) begin
         decode = bit_timing_pkg::REG_STATUS;
      end else if (a[11:2] == `OFS_BIT_TIMING >> 2) begin
         decode = bit_timing_pkg::REG_TIMING;
      end else if (a[11:2] == `OFS_PRESCALER_EXT >> 2) begin
         decode = bit_timing_pkg::REG_EXT;
      end else begin
         decode = bit_timing_pkg::REG_NONE;
      end
   endfunction

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      merge = r;
   endfunction

   // Smaller of a phase error and the jump width
   function automatic logic [4:0] min_q(input logic [4:0] a, input logic [4:0] b);
      min_q = (a < b) ? a : b;
   endfunction

   // Length of a run of equal bits after one more bit
   function automatic logic [2:0] run_next(input logic [2:0] run,
      input logic last, input logic b, input logic en);
      if (!en) begin
         run_next = 3'h0;
      end else if (b == last && run != 3'h0) begin
         run_next = run + 3'h1;
      end else begin
         run_next = 3'h1;
      end
   endfunction

   logic aw_held, w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic init;
   logic [15:0] bit_timing_config;
   logic [3:0] prescaler_extension;
   logic rx_meta, rx_sync, rx_prev, edge_pend;
   logic [9:0] pres_cnt;
   bit_timing_pkg::seg_t seg;
   logic [4:0] q_cnt, lim1, lim2;
   logic sync_done, last_sample;
   logic tx_next, tx_last, rx_last;
   logic [2:0] tx_run, rx_run;
   logic [3:0] idle_cnt;

   // Register bus handshakes
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !s_axi_rvalid;
   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire bit_timing_pkg::reg_id_t wr_id = decode(aw_addr);
   wire bit_timing_pkg::reg_id_t rd_id = decode(s_axi_araddr);
   wire [31:0] ctl_word = {31'h0, init};
   wire [31:0] sts_word = {1'b0, crc, 12'h0, crc == 15'h0, stuff_error,
      rx_sync, bus_idle};
   // Timing fields only change while the controller is held in init
   wire cfg_we = do_write && init && wr_id == bit_timing_pkg::REG_TIMING;
   wire ext_we = do_write && init && wr_id == bit_timing_pkg::REG_EXT;
   wire [31:0] cfg_merged = merge({16'h0, bit_timing_config}, w_data, w_strb);
   wire [31:0] ext_merged = merge({28'h0, prescaler_extension}, w_data, w_strb);
   wire [31:0] ctl_merged = merge(ctl_word, w_data, w_strb);
   wire [31:0] sts_merged = merge(32'h0, w_data, w_strb);

   // Stored fields are functional value minus one
   wire [5:0] brp_f = bit_timing_config[`BRP_LSB +: 6];
   wire [4:0] sjw1 = {3'h0, bit_timing_config[`SJW_LSB +: 2]} + 5'h1;
   wire [4:0] segment_one_field_f = {1'b0, bit_timing_config[`SEGMENT_ONE_FIELD_LSB +: 4]};
   wire [4:0] segment_two_field_f = {2'h0, bit_timing_config[`SEGMENT_TWO_FIELD_LSB +: 3]};
   // Divide of 1..1024 from extension and prescaler
   wire [9:0] divide_m1 = {prescaler_extension, brp_f};

   // Write address and data are caught in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 12'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_id == bit_timing_pkg::REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read data registered one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         if (rd_id == bit_timing_pkg::REG_CONTROL) begin
            s_axi_rdata <= ctl_word;
         end else if (rd_id == bit_timing_pkg::REG_STATUS) begin
            s_axi_rdata <= sts_word;
         end else if (rd_id == bit_timing_pkg::REG_TIMING) begin
            s_axi_rdata <= {16'h0, bit_timing_config};
         end else if (rd_id == bit_timing_pkg::REG_EXT) begin
            s_axi_rdata <= {28'h0, prescaler_extension};
         end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         init <= 1'(`RST_CONTROL);
         bit_timing_config <= `RST_BIT_TIMING;
         prescaler_extension <= `RST_PRESCALER_EXT;
      end else begin
         if (do_write && wr_id == bit_timing_pkg::REG_CONTROL) begin
            init <= ctl_merged[`CTL_INIT];
         end
         if (cfg_we) begin
            bit_timing_config <= cfg_merged[15:0];
         end
         if (ext_we) begin
            prescaler_extension <= ext_merged[3:0];
         end
      end
   end

   // Two-flop synchroniser on the bus input, then edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= rx_pin;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end
   wire fall = rx_prev && !rx_sync;

   // Quantum tick: aclk stands for the 8 MHz controller clock, tq = divide/fclk
   wire tq_tick = !init && pres_cnt == divide_m1;
   always_ff @(posedge aclk) begin
      if (!aresetn || init || tq_tick) begin
         pres_cnt <= 10'h0;
      end else begin
         pres_cnt <= pres_cnt + 10'h1;
      end
   end

   // Edges seen between ticks are held so the decision waits for a quantum
   always_ff @(posedge aclk) begin
      if (!aresetn || init) begin
         edge_pend <= 1'b0;
      end else if (fall) begin
         edge_pend <= 1'b1;
      end else if (tq_tick) begin
         edge_pend <= 1'b0;
      end
   end

   // Sync decisions, each taken once per quantum
   wire edge_q = tq_tick && edge_pend;
   wire hard = edge_q && bus_idle;
   wire resync_ok = edge_q && !bus_idle && !sync_done && last_sample;
   // Late edge: phase error is quanta since sync ended
   wire late = resync_ok && seg == bit_timing_pkg::SEG_ONE;
   wire [4:0] late_adj = min_q(q_cnt + 5'h1, sjw1);
   // Early edge: phase error is quanta left before the next sync
   wire early = resync_ok && seg == bit_timing_pkg::SEG_TWO;
   wire [4:0] early_err = lim2 - q_cnt + 5'h1;
   wire early_restart = early && early_err <= sjw1;
   wire [4:0] lim2_eff = early ? lim2 - sjw1 : lim2;
   wire [4:0] lim1_eff = late ? lim1 + late_adj : lim1;
   wire at_sample = tq_tick && !hard && seg == bit_timing_pkg::SEG_ONE &&
      q_cnt >= lim1_eff;
   wire tx_stuff = stuff_en && tx_run == `STUFF_RUN;
   wire rx_stuff = stuff_en && rx_run == `STUFF_RUN;

   // Segment sequencer: sync, segment one (prop+phase1), segment two
   always_ff @(posedge aclk) begin
      if (!aresetn || init) begin
         seg <= bit_timing_pkg::SEG_SYNC;
         q_cnt <= 5'h0;
         lim1 <= 5'h0;
         lim2 <= 5'h0;
         sync_done <= 1'b0;
      end else if (hard || early_restart) begin
         // Edge quantum served as this bit's sync; phase two cut short
         seg <= bit_timing_pkg::SEG_ONE;
         q_cnt <= 5'h0;
         lim1 <= segment_one_field_f;
         lim2 <= segment_two_field_f;
         sync_done <= early_restart;
      end else if (tq_tick) begin
         case (seg)
            bit_timing_pkg::SEG_SYNC: begin
               // Fixed single quantum; limits reload so resync is per bit
               seg <= bit_timing_pkg::SEG_ONE;
               q_cnt <= 5'h0;
               lim1 <= segment_one_field_f;
               lim2 <= segment_two_field_f;
               sync_done <= 1'b0;
            end
            bit_timing_pkg::SEG_ONE: begin
               lim1 <= lim1_eff;
               sync_done <= sync_done || late;
               if (q_cnt >= lim1_eff) begin
                  seg <= bit_timing_pkg::SEG_TWO;
                  q_cnt <= 5'h0;
               end else begin
                  q_cnt <= q_cnt + 5'h1;
               end
            end
            bit_timing_pkg::SEG_TWO: begin
               lim2 <= lim2_eff;
               sync_done <= sync_done || early;
               // Bit ends after segment_one_field+segment_two_field+3 quanta unless resynced
               if (q_cnt >= lim2_eff) begin
                  seg <= bit_timing_pkg::SEG_SYNC;
                  q_cnt <= 5'h0;
               end else begin
                  q_cnt <= q_cnt + 5'h1;
               end
            end
            default: begin
               seg <= bit_timing_pkg::SEG_SYNC;
            end
         endcase
      end
   end

   // Transmit: next bit chosen at the sample point, driven from sync.
   // Nothing is computed after the sample point, so a cut phase two is safe.
   assign tx_taken = at_sample && !tx_stuff;
   always_ff @(posedge aclk) begin
      if (!aresetn || init) begin
         tx_next <= 1'b1;
         tx_last <= 1'b1;
         tx_run <= 3'h0;
         tx_pin <= 1'b1;
      end else begin
         if (at_sample) begin
            // Complement inserted after five equal bits
            tx_next <= tx_stuff ? !tx_last : tx_bit;
            tx_last <= tx_stuff ? !tx_last : tx_bit;
            tx_run <= run_next(tx_run, tx_last, tx_stuff ? !tx_last : tx_bit, stuff_en);
         end
         if (tq_tick && (seg == bit_timing_pkg::SEG_SYNC || hard || early_restart)) begin
            tx_pin <= tx_next;
         end
      end
   end

   // Receive: sample, remove stuff bits, check stuff rule
   always_ff @(posedge aclk) begin
      if (!aresetn || init) begin
         rx_bit <= 1'b1;
         rx_valid <= 1'b0;
         sample_point <= 1'b0;
         rx_last <= 1'b1;
         rx_run <= 3'h0;
         last_sample <= 1'b1;
      end else begin
         sample_point <= at_sample;
         rx_valid <= at_sample && !rx_stuff;
         if (at_sample) begin
            last_sample <= rx_sync;
            rx_last <= rx_sync;
            rx_run <= rx_stuff ? 3'h1 : run_next(rx_run, rx_last, rx_sync, stuff_en);
            if (!rx_stuff) begin
               rx_bit <= rx_sync;
            end
         end
      end
   end

   // Sticky stuff error; a new error wins over a write-one clear
   wire stuff_set = at_sample && rx_stuff && rx_sync == rx_last;
   wire stuff_clr = do_write && wr_id == bit_timing_pkg::REG_STATUS &&
      sts_merged[`STS_STUFF_ERR];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stuff_error <= 1'b0;
      end else if (stuff_set) begin
         stuff_error <= 1'b1;
      end else if (stuff_clr) begin
         stuff_error <= 1'b0;
      end
   end

   // CRC over destuffed received bits; zero remainder means check passed
   wire crc_fb = rx_bit ^ crc[14];
   always_ff @(posedge aclk) begin
      if (!aresetn || crc_clear) begin
         crc <= 15'h0;
      end else if (rx_valid) begin
         crc <= {crc[13:0], 1'b0} ^ (crc_fb ? `CRC_POLY : 15'h0);
      end
   end

   // Idle after eleven recessive samples; left on hard sync
   always_ff @(posedge aclk) begin
      if (!aresetn || init) begin
         idle_cnt <= 4'h0;
         bus_idle <= 1'b0;
      end else if (hard) begin
         idle_cnt <= 4'h0;
         bus_idle <= 1'b0;
      end else if (at_sample) begin
         if (!rx_sync) begin
            idle_cnt <= 4'h0;
         end else if (idle_cnt == `IDLE_BITS - 4'h1) begin
            bus_idle <= 1'b1;
         end else begin
            idle_cnt <= idle_cnt + 4'h1;
         end
      end
   end

endmodule

// >>> test/can_bit_timing_logic_sva.sv
// Port assertions for the bit timing block.
// Bound to the design top; needs nothing but its ports.
`timescale 1ns/1ps
module can_bit_timing_logic_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tx_taken,
   input wire logic rx_valid,
   input wire logic sample_point,
   input wire logic stuff_error,
   input wire logic crc_clear,
   input wire logic [14:0] crc
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Bus answers stand until taken
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken while read pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   // Transmit and receive both land on the sample point
   a_take_at_sample: assert property (tx_taken |=> sample_point)
      else $error("bit taken off the sample point");
   a_rx_at_sample: assert property (rx_valid |-> sample_point)
      else $error("bit received off the sample point");
   // Shortest legal bit still leaves two idle cycles between samples
   a_sample_spacing: assert property (sample_point |=> !sample_point [*2])
      else $error("sample points too close");
   // Only a status write may clear the error flag
   a_stuff_sticky: assert property (stuff_error && s_axi_awready && s_axi_wready
      && !s_axi_bvalid |=> stuff_error) else $error("stuff error lost");
   a_crc_cleared: assert property (crc_clear |=> crc == 15'h0)
      else $error("crc not cleared");
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_stuff_err: cover property ($rose(stuff_error));
   c_rx_bit: cover property (rx_valid ##1 !rx_valid);
endmodule

bind can_bit_timing_logic can_bit_timing_logic_sva i_can_bit_timing_logic_sva (.*);

// >>> test/can_bus_node_model.sv
// Bus seen through a transceiver, with one other node on it.
// Assumes other_dom is driven on aclk edges by the testbench.
`timescale 1ns/1ps
module can_bus_node_model #(
   parameter int DELAY = 3
) (
   input wire logic aclk,
   input wire logic tx_pin,
   input wire logic other_dom,
   output logic rx_pin
);
   logic [DELAY-1:0] line = '1;
   // Own bits come back after the cable and transceiver loop delay
   always_ff @(posedge aclk) begin
      line <= {line[DELAY-2:0], tx_pin};
   end
   // Wired-AND: any dominant node wins, the bus rests recessive
   assign rx_pin = line[DELAY-1] & !other_dom;
endmodule

// >>> test/can_bit_timing_logic_tb_top.sv
// Self-checking bench: register tasks and bus scenarios.
// Assumes the bus model loops tx back after a few cycles.
`timescale 1ns/1ps
`include "bit_timing_defs.svh"
module can_bit_timing_logic_tb_top;
   logic aclk;
   logic aresetn;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic rx_pin, tx_pin, tx_bit, stuff_en, crc_clear, tx_taken, rx_bit, rx_valid;
   logic sample_point, bus_idle, stuff_error, other_dom, chk_rx, stuffd;
   logic tk, rv, sp, rb, tkd, last_bit, prev_bit, fb;
   logic [14:0] crc, exp_crc;
   logic [15:0] pat;
   logic [3:0] pidx;
   int miscompares, samples_checked, cycles, run, last_run, nstuff, n, d0, t;
   logic [31:0] cfg [5] = '{32'h2301, 32'h1440, 32'h34c7, 32'h7f00, 32'h0100};
   logic [31:0] ext [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hf};
   logic [31:0] len [5] = '{32'd16, 32'd8, 32'd80, 32'd25, 32'd3844};

   can_bit_timing_logic i_can_bit_timing_logic (.*);
   can_bus_node_model i_can_bus_node_model (.aclk(aclk), .tx_pin(tx_pin),
      .other_dom(other_dom), .rx_pin(rx_pin));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, hb;
      logic [1:0] r;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid && s_axi_bready;
         if (hb) r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (hb) s_axi_bready <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
      chk({30'h0, r}, {30'h0, er});
      // One idle edge so the next call never re-raises a strobe in this step
      @(posedge aclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
         input logic [1:0] er);
      logic ta, hr;
      logic [31:0] d;
      logic [1:0] r;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid && s_axi_rready;
         if (hr) d = s_axi_rdata;
         if (hr) r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (hr) s_axi_rready <= 1'b0;
      end while (s_axi_arvalid || s_axi_rready);
      chk(d & m, e & m);
      chk({30'h0, r}, {30'h0, er});
      @(posedge aclk);
   endtask

   // Cycles up to the next sample point, bounded
   task automatic wsp(output int k);
      k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while (sample_point !== 1'b1 && k < 4000);
      @(posedge aclk);
   endtask

   task automatic widle();
      int k;
      k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while (bus_idle !== 1'b1 && k < 5000);
      @(posedge aclk);
   endtask

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Pulses are read mid-cycle so the edge that follows never races them
   always @(negedge aclk) begin
      tk = tx_taken;
      rv = rx_valid;
      sp = sample_point;
      rb = rx_bit;
   end

   // Frame-side stand-in: feeds bits, checks echoes, tracks stuff runs
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      tkd <= tk;
      if (tk) begin
         tx_bit <= pat[pidx];
         pidx <= pidx + 4'h1;
         prev_bit <= last_bit;
         last_bit <= tx_bit;
      end
      if (rv && chk_rx) begin
         chk({31'h0, rb}, {31'h0, prev_bit});
         fb = prev_bit ^ exp_crc[14];
         exp_crc <= {exp_crc[13:0], 1'b0} ^ (fb ? `CRC_POLY : 15'h0);
      end
      if (sp && stuff_en && !tkd) begin
         last_run <= run;
         run <= 0;
         nstuff <= nstuff + 1;
      end else if (sp && stuff_en) begin
         run <= run + 1;
      end
      // The echoed stuff bit is sampled one bit after it is sent
      if (sp && stuff_en) begin
         if (stuffd && !other_dom) chk({31'h0, rv}, 32'h0);
         stuffd <= !tkd;
      end
      if (cycles == 40000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {stuff_en, crc_clear, other_dom, chk_rx, tkd, stuffd} = '0;
      {tx_bit, last_bit, prev_bit} = 3'h7;
      pat = 16'hffff;
      pidx = 4'h0;
      exp_crc = 15'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, unmapped read and write
      rd(12'h000, 32'hffffffff, 32'h1, 2'h0);
      rd(12'h00c, 32'hffffffff, 32'h2301, 2'h0);
      rd(12'h018, 32'hffffffff, 32'h0, 2'h0);
      rd(12'h008, 32'hffffffff, 32'h0, 2'h2);
      wr(12'h020, 32'h1, 2'h2);
      $display("test registers done");
      // Bit length at field limits and with the prescaler extension
      for (int i = 0; i < 5; i++) begin
         wr(12'h000, 32'h1, 2'h0);
         wr(12'h00c, cfg[i], 2'h0);
         chk({31'h0, tx_pin}, 32'h1);
         wr(12'h018, ext[i], 2'h0);
         rd(12'h00c, 32'hffff, cfg[i], 2'h0);
         wr(12'h000, 32'h0, 2'h0);
         repeat (3) wsp(n);
         chk(32'(n), len[i]);
      end
      // Timing is locked while running
      wr(12'h00c, 32'h0, 2'h0);
      rd(12'h00c, 32'hffff, 32'h0100, 2'h0);
      wr(12'h000, 32'h1, 2'h0);
      wr(12'h00c, 32'h34c7, 2'h0);
      wr(12'h018, 32'h0, 2'h0);
      wr(12'h000, 32'h0, 2'h0);
      $display("test bit length done");
      // Idle-bus edge at two bit phases must give the same sample distance
      for (int i = 0; i < 2; i++) begin
         widle();
         chk({31'h0, bus_idle}, 32'h1);
         repeat (40 * i) @(posedge aclk);
         other_dom <= 1'b1;
         wsp(n);
         other_dom <= 1'b0;
         if (i == 0) d0 = n;
      end
      chk(32'(n), 32'(d0));
      $display("test hard sync done");
      // Echoed bits and their crc
      widle();
      crc_clear <= 1'b1;
      pat <= 16'hb3a5;
      wsp(n);
      repeat (10) @(posedge aclk);
      crc_clear <= 1'b0;
      exp_crc <= 15'h0;
      chk_rx <= 1'b1;
      repeat (20) wsp(n);
      repeat (2) @(posedge aclk);
      chk({17'h0, crc}, {17'h0, exp_crc});
      chk_rx <= 1'b0;
      $display("test echo done");
      // Stuff bit after five equal bits, then a forced stuff error
      stuff_en <= 1'b1;
      pat <= 16'h0;
      t = nstuff + 2;
      do @(negedge aclk); while (nstuff < t && cycles < 40000);
      @(posedge aclk);
      chk(32'(last_run), 32'h5);
      rd(12'h004, 32'h4, 32'h0, 2'h0);
      other_dom <= 1'b1;
      t = nstuff + 1;
      do @(negedge aclk); while (nstuff < t && cycles < 40000);
      repeat (2) wsp(n);
      other_dom <= 1'b0;
      stuff_en <= 1'b0;
      pat <= 16'hffff;
      rd(12'h004, 32'h4, 32'h4, 2'h0);
      repeat (2) wsp(n);
      wr(12'h004, 32'h4, 2'h0);
      rd(12'h004, 32'h4, 32'h0, 2'h0);
      $display("test stuffing done");
      end_of_test();
   end
endmodule
